// ---- oms_pkg.sv ----
package oms_pkg;
  // clock_mode_field encodings
  localparam logic [3:0] OMS_MODE_LOW_POWER_CRYSTAL = 4'h0;
  localparam logic [3:0] OMS_MODE_STANDARD_CRYSTAL  = 4'h1;
  localparam logic [3:0] OMS_MODE_FAST_CRYSTAL      = 4'h2;
  localparam logic [3:0] OMS_MODE_RC_CLKOUT         = 4'h3;
  localparam logic [3:0] OMS_MODE_DRIVEN_CLKOUT     = 4'h4;
  localparam logic [3:0] OMS_MODE_DRIVEN_PIN        = 4'h5;
  localparam logic [3:0] OMS_MODE_FAST_X4           = 4'h6;
  localparam logic [3:0] OMS_MODE_RC_PIN            = 4'h7;
  localparam logic [3:0] OMS_MODE_ON_CHIP_TWO_PIN   = 4'h8;
  localparam logic [3:0] OMS_MODE_ON_CHIP_CLKOUT    = 4'h9;
  // on_chip_freq_field encodings
  localparam logic [2:0] OMS_FREQ_SLOW     = 3'h0;
  localparam logic [2:0] OMS_FREQ_125K     = 3'h1;
  localparam logic [2:0] OMS_FREQ_4M       = 3'h6;
  localparam logic [2:0] OMS_FREQ_8M       = 3'h7;
  // reset values
  localparam logic [3:0] OMS_MODE_RESET    = 4'h7;
  localparam logic [1:0] OMS_DIV4_RESET    = 2'h0;
  localparam logic [1:0] OMS_DIV4_HALF     = 2'h2;
  // clock source select codes
  localparam logic [1:0] OMS_SRC_PRIMARY   = 2'h0;
  localparam logic [1:0] OMS_SRC_MAIN      = 2'h1;
  localparam logic [1:0] OMS_SRC_SLOW      = 2'h2;
  localparam logic [1:0] OMS_SRC_POSTSCALE = 2'h3;
  // clock origin codes
  typedef enum logic [1:0] {
    OMS_ORIGIN_CRYSTAL = 2'b00,
    OMS_ORIGIN_RC      = 2'b01,
    OMS_ORIGIN_DRIVEN  = 2'b10,
    OMS_ORIGIN_ON_CHIP = 2'b11
  } oms_origin_e;
endpackage

// ---- oms_div4.sv ----
module oms_div4
  import oms_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rst,
  output logic      o_div4
);
  logic [1:0] count_reg;

  // free-running counter, msb is a symmetric quarter-rate clock
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      count_reg <= OMS_DIV4_RESET;
    end else begin
      count_reg <= count_reg + 2'h1;
    end
  end

  assign o_div4 = count_reg[1];
endmodule

// ---- oms_mode_select.sv ----
// Operation
// - ten modes picked by four-bit field
// - rc clkout mode drives core/4 out
// - rc pin mode makes out pin io
// - driven mode takes input pin, outputs /4
// - driven pin mode makes out pin io
// - driven modes skip oscillator start-up delay
// - fast x4 mode multiplies crystal by four
// - pll on crystal only in x4 code
// - software pll bit ignored in x4
// - software may enable pll on on-chip clock
// - 8 MHz on-chip clock and postscaler
// - main clock enabled for 125k..8M
// - slow clock enabled by selection or features
// - freq field picks main, slow or postscaled
// - on-chip modes: clkout/io or two io
// - on-chip pll only at 4 or 8 MHz
// - pll bit reads zero outside on-chip modes
module oms_mode_select
  import oms_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic [3:0] i_clock_mode_field,
  input  wire logic [2:0] i_on_chip_freq_field,
  input  wire logic       i_multiplier_on_bit,
  input  wire logic       i_powerup_timer_en,
  input  wire logic       i_failsafe_monitor_en,
  input  wire logic       i_watchdog_en,
  input  wire logic       i_two_speed_en,
  input  wire logic       i_port_a_bit_six_out,
  input  wire logic       i_port_a_bit_six_oe,
  input  wire logic       i_port_a_bit_seven_out,
  input  wire logic       i_port_a_bit_seven_oe,
  output logic [3:0]      o_active_mode,
  output logic            o_mode_valid,
  output logic [1:0]      o_clock_origin,
  output logic            o_crystal_amp_en,
  output logic            o_startup_delay_en,
  output logic            o_crystal_pll_en,
  output logic            o_on_chip_pll_en,
  output logic            o_multiplier_on_bit_rd,
  output logic            o_main_on_chip_en,
  output logic            o_slow_on_chip_en,
  output logic [1:0]      o_clock_src_sel,
  output logic [2:0]      o_postscale_sel,
  output logic            o_clock_out_pin_out,
  output logic            o_clock_out_pin_oe,
  output logic            o_clock_in_pin_out,
  output logic            o_clock_in_pin_oe
);
  logic [3:0] mode_reg;
  logic       div4;
  logic       mode_ok;
  logic       is_crystal;
  logic       is_rc;
  logic       is_driven;
  logic       is_on_chip;
  logic       out_pin_clkout;
  logic       out_pin_io;
  logic       in_pin_io;
  logic       on_chip_src;
  logic       pll_freq_ok;
  logic       pll_allowed;
  logic       freq_slow;
  logic       freq_main_direct;
  logic       main_need;
  logic       slow_need;
  logic [1:0] src_sel;
  oms_origin_e origin;
  logic [3:0] active_mode_next;
  logic       crystal_pll_next;
  logic       on_chip_pll_next;
  logic       multiplier_rd_next;
  logic       out_pin_out_next;
  logic       out_pin_oe_next;
  logic       in_pin_out_next;
  logic       in_pin_oe_next;

  // quarter-rate clock for the clkout pin
  oms_div4 u_div4 (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .o_div4 (div4)
  );

  // the field is non-volatile; it is sampled on every clock after reset, so a
  // change of the field reaches the mode one cycle later
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mode_reg <= OMS_MODE_RESET;
    end else begin
      mode_reg <= i_clock_mode_field;
    end
  end

  // mode decode; codes beyond the ten fall back to rc with io pin
  assign mode_ok    = (mode_reg <= OMS_MODE_ON_CHIP_CLKOUT);
  assign is_crystal = mode_ok && (mode_reg == OMS_MODE_LOW_POWER_CRYSTAL ||
                      mode_reg == OMS_MODE_STANDARD_CRYSTAL ||
                      mode_reg == OMS_MODE_FAST_CRYSTAL ||
                      mode_reg == OMS_MODE_FAST_X4);
  assign is_driven  = mode_ok && (mode_reg == OMS_MODE_DRIVEN_CLKOUT ||
                      mode_reg == OMS_MODE_DRIVEN_PIN);
  assign is_on_chip = mode_ok && (mode_reg == OMS_MODE_ON_CHIP_CLKOUT ||
                      mode_reg == OMS_MODE_ON_CHIP_TWO_PIN);
  assign is_rc      = !is_crystal && !is_driven && !is_on_chip;

  assign origin = is_crystal ? OMS_ORIGIN_CRYSTAL :
                  is_driven  ? OMS_ORIGIN_DRIVEN  :
                  is_rc      ? OMS_ORIGIN_RC      : OMS_ORIGIN_ON_CHIP;

  // clock_out_pin role per mode
  assign out_pin_clkout = mode_ok && (mode_reg == OMS_MODE_RC_CLKOUT ||
                          mode_reg == OMS_MODE_DRIVEN_CLKOUT ||
                          mode_reg == OMS_MODE_ON_CHIP_CLKOUT);
  assign out_pin_io     = !is_crystal && !out_pin_clkout;
  assign in_pin_io      = is_on_chip;

  // pll gating
  assign on_chip_src = is_on_chip;
  assign pll_freq_ok = (i_on_chip_freq_field == OMS_FREQ_4M) ||
                       (i_on_chip_freq_field == OMS_FREQ_8M);
  assign pll_allowed = on_chip_src && pll_freq_ok;

  // on-chip source selection and enables
  assign freq_slow        = (i_on_chip_freq_field == OMS_FREQ_SLOW);
  assign freq_main_direct = (i_on_chip_freq_field == OMS_FREQ_8M);
  assign src_sel = !on_chip_src     ? OMS_SRC_PRIMARY :
                   freq_slow        ? OMS_SRC_SLOW    :
                   freq_main_direct ? OMS_SRC_MAIN    : OMS_SRC_POSTSCALE;
  // any setting from 125k up to 8M needs the main source running
  assign main_need = on_chip_src && (i_on_chip_freq_field >= OMS_FREQ_125K);
  assign slow_need = (on_chip_src && freq_slow) || i_powerup_timer_en ||
                     i_failsafe_monitor_en || i_watchdog_en || i_two_speed_en;

  // next values of the registered outputs; reserved codes report as rc pin
  assign active_mode_next   = mode_ok ? mode_reg : OMS_MODE_RC_PIN;
  assign crystal_pll_next   = mode_ok && (mode_reg == OMS_MODE_FAST_X4);
  assign on_chip_pll_next   = pll_allowed && i_multiplier_on_bit;
  // the bit survives any frequency inside on-chip modes, so software need not
  // rewrite it after passing through a slow setting
  assign multiplier_rd_next = on_chip_src && i_multiplier_on_bit;
  assign out_pin_out_next   = out_pin_clkout ? div4 : (out_pin_io && i_port_a_bit_six_out);
  assign out_pin_oe_next    = out_pin_clkout || (out_pin_io && i_port_a_bit_six_oe);
  assign in_pin_out_next    = in_pin_io && i_port_a_bit_seven_out;
  assign in_pin_oe_next     = in_pin_io && i_port_a_bit_seven_oe;

  // mode report
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_active_mode  <= OMS_MODE_RESET;
      o_mode_valid   <= 1'b0;
      o_clock_origin <= OMS_ORIGIN_RC;
    end else begin
      o_active_mode  <= active_mode_next;
      o_mode_valid   <= mode_ok;
      o_clock_origin <= origin;
    end
  end

  // crystal amplifier, start-up timer and crystal pll
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_crystal_amp_en   <= 1'b0;
      o_startup_delay_en <= 1'b0;
      o_crystal_pll_en   <= 1'b0;
    end else begin
      // fast crystal amp also tolerates a driven input clock
      o_crystal_amp_en   <= is_crystal;
      // only a crystal needs settling time; driven clocks run at once
      o_startup_delay_en <= is_crystal;
      o_crystal_pll_en   <= crystal_pll_next;
    end
  end

  // on-chip pll enable and readback of the software bit
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_on_chip_pll_en       <= 1'b0;
      o_multiplier_on_bit_rd <= 1'b0;
    end else begin
      o_on_chip_pll_en       <= on_chip_pll_next;
      o_multiplier_on_bit_rd <= multiplier_rd_next;
    end
  end

  // on-chip oscillator enables
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_main_on_chip_en <= 1'b0;
      o_slow_on_chip_en <= 1'b0;
    end else begin
      o_main_on_chip_en <= main_need;
      o_slow_on_chip_en <= slow_need;
    end
  end

  // source and postscaler selection
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_clock_src_sel <= OMS_SRC_PRIMARY;
      o_postscale_sel <= OMS_FREQ_SLOW;
    end else begin
      o_clock_src_sel <= src_sel;
      o_postscale_sel <= i_on_chip_freq_field;
    end
  end

  // out pin driver; io-mode pin is handed to the port logic
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_clock_out_pin_out <= 1'b0;
      o_clock_out_pin_oe  <= 1'b0;
    end else begin
      o_clock_out_pin_out <= out_pin_out_next;
      o_clock_out_pin_oe  <= out_pin_oe_next;
    end
  end

  // in pin driver, only used as io in on-chip modes
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_clock_in_pin_out <= 1'b0;
      o_clock_in_pin_oe  <= 1'b0;
    end else begin
      o_clock_in_pin_out <= in_pin_out_next;
      o_clock_in_pin_oe  <= in_pin_oe_next;
    end
  end
endmodule

// ---- oms_mode_select_assertions.sv ----
module oms_mode_select_chk
  import oms_pkg::*;
(
  input wire logic       i_clk,
  input wire logic       i_rst,
  input wire logic [3:0] i_clock_mode_field,
  input wire logic [2:0] i_on_chip_freq_field,
  input wire logic       i_watchdog_en,
  input wire logic [3:0] o_active_mode,
  input wire logic       o_mode_valid,
  input wire logic [1:0] o_clock_origin,
  input wire logic       o_startup_delay_en,
  input wire logic       o_crystal_pll_en,
  input wire logic       o_on_chip_pll_en,
  input wire logic       o_main_on_chip_en,
  input wire logic       o_slow_on_chip_en,
  input wire logic       o_clock_out_pin_out,
  input wire logic       o_clock_out_pin_oe
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // clkout pin phase is only meaningful while a clkout mode stays selected
  wire ck = o_clock_out_pin_oe && (o_active_mode inside {4'h3, 4'h4, 4'h9});
  wire oc = (o_clock_origin == OMS_ORIGIN_ON_CHIP);
  sequence s_bad_code_held;
    (i_clock_mode_field > 4'h9) ##1 $stable(i_clock_mode_field);
  endsequence
  sequence s_rise_in_clkout;
    ck && $past(ck) && $rose(o_clock_out_pin_out) ##1 ck ##1 ck;
  endsequence
  sequence s_fall_in_clkout;
    ck && $past(ck) && $fell(o_clock_out_pin_out) ##1 ck ##1 ck;
  endsequence
  a_bad_code_rcpin: assert property (s_bad_code_held |=> !o_mode_valid && o_active_mode == 4'h7)
    else $error("reserved code not mapped");
  a_x4_pll_only: assert property (o_crystal_pll_en |-> o_active_mode == 4'h6 && !o_on_chip_pll_en)
    else $error("crystal pll outside x4");
  a_no_startup_driven: assert property (o_clock_origin == OMS_ORIGIN_DRIVEN |-> !o_startup_delay_en)
    else $error("start-up delay in driven mode");
  a_pll_on_chip: assert property (o_on_chip_pll_en |-> oc && $past(i_on_chip_freq_field) >= 3'h6)
    else $error("on-chip pll not allowed");
  a_slow_watchdog: assert property (i_watchdog_en |=> o_slow_on_chip_en)
    else $error("slow clock off with watchdog");
  a_main_freq_range: assert property (o_main_on_chip_en |-> oc && $past(i_on_chip_freq_field) != 3'h0)
    else $error("main clock on out of range");
  a_div4_high_two: assert property (s_rise_in_clkout |-> $past(o_clock_out_pin_out) && !o_clock_out_pin_out)
    else $error("div4 high phase wrong");
  a_div4_low_two: assert property (s_fall_in_clkout |-> !$past(o_clock_out_pin_out) && o_clock_out_pin_out)
    else $error("div4 low phase wrong");
endmodule

bind oms_mode_select oms_mode_select_chk u_chk (.*);

// ---- oms_mode_select_tb_top.sv ----
module oms_mode_select_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import oms_pkg::*;
  logic       i_clk = 1'b0;
  logic       i_rst = 1'b1;
  logic [3:0] i_clock_mode_field = 4'h0;
  logic [2:0] i_on_chip_freq_field = 3'h0;
  logic       i_multiplier_on_bit = 0, i_powerup_timer_en = 0, i_failsafe_monitor_en = 0, i_watchdog_en = 0;
  logic       i_two_speed_en = 0, i_port_a_bit_six_out = 0, i_port_a_bit_six_oe = 0;
  logic       i_port_a_bit_seven_out = 0, i_port_a_bit_seven_oe = 0;
  logic [3:0] o_active_mode, em;
  logic [1:0] o_clock_origin, o_clock_src_sel, org;
  logic [2:0] o_postscale_sel, f;
  logic       o_mode_valid, o_crystal_amp_en, o_startup_delay_en, o_crystal_pll_en, o_on_chip_pll_en;
  logic       o_multiplier_on_bit_rd, o_main_on_chip_en, o_slow_on_chip_en, o_clock_out_pin_out;
  logic       o_clock_out_pin_oe, o_clock_in_pin_out, o_clock_in_pin_oe, oc;
  logic [7:0] wav;
  int         num_errors = 0;
  int         checked = 0;
  // free-running core clock, 4 ns period
  always #2 i_clk = ~i_clk;
  oms_mode_select DUT (.*);
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("errors=%0d checked=%0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // clock origin of each valid mode code
  function automatic logic [1:0] org_of(input logic [3:0] m);
    case (m)
      4'h0, 4'h1, 4'h2, 4'h6: return OMS_ORIGIN_CRYSTAL;
      4'h3, 4'h7: return OMS_ORIGIN_RC;
      4'h4, 4'h5: return OMS_ORIGIN_DRIVEN;
      default: return OMS_ORIGIN_ON_CHIP;
    endcase
  endfunction
  // watchdog: the sweep needs well under 5000 ns
  initial begin
    #20000;
    num_errors++;
    test_done();
  end
  // first sixteen passes walk every code, reserved ones included
  initial begin
    void'($urandom(42551));
    repeat (10) @(posedge i_clk);
    @(negedge i_clk) i_rst = 1'b0;
    for (int i = 0; i < 80; i++) begin
      @(negedge i_clk);
      i_clock_mode_field = (i < 16) ? 4'(i) : 4'($urandom % 16);
      {i_on_chip_freq_field, i_multiplier_on_bit, i_port_a_bit_six_out, i_port_a_bit_six_oe,
       i_port_a_bit_seven_out, i_port_a_bit_seven_oe} = 8'($urandom);
      if (i % 5 == 0) {i_on_chip_freq_field, i_multiplier_on_bit} = 4'hf;
      {i_powerup_timer_en, i_failsafe_monitor_en, i_watchdog_en, i_two_speed_en} =
        ($urandom % 3 == 0) ? 4'($urandom) : 4'h0;
      repeat (3) @(negedge i_clk);
      em = (i_clock_mode_field > 4'h9) ? OMS_MODE_RC_PIN : i_clock_mode_field;
      org = org_of(em);
      oc = (org == OMS_ORIGIN_ON_CHIP);
      f = i_on_chip_freq_field;
      chk(o_active_mode, em);
      chk({3'h0, o_mode_valid}, {3'h0, i_clock_mode_field <= 4'h9});
      chk({o_clock_origin, o_crystal_amp_en, o_startup_delay_en}, {org, {2{org == OMS_ORIGIN_CRYSTAL}}});
      chk({o_crystal_pll_en, o_on_chip_pll_en, o_main_on_chip_en, o_slow_on_chip_en},
          {em == OMS_MODE_FAST_X4, oc && i_multiplier_on_bit && f >= OMS_FREQ_4M, oc && f != OMS_FREQ_SLOW,
           (oc && f == OMS_FREQ_SLOW) || i_powerup_timer_en || i_failsafe_monitor_en || i_watchdog_en
           || i_two_speed_en});
      chk({3'h0, o_multiplier_on_bit_rd}, {3'h0, oc && i_multiplier_on_bit});
      chk({2'h0, o_clock_src_sel}, {2'h0, !oc ? OMS_SRC_PRIMARY : (f == OMS_FREQ_SLOW) ? OMS_SRC_SLOW :
          (f == OMS_FREQ_8M) ? OMS_SRC_MAIN : OMS_SRC_POSTSCALE});
      chk({1'h0, o_postscale_sel}, {1'h0, f});
      if (em inside {4'h5, 4'h7, 4'h8}) chk({2'h0, o_clock_out_pin_out, o_clock_out_pin_oe},
          {2'h0, i_port_a_bit_six_out, i_port_a_bit_six_oe});
      if (org == OMS_ORIGIN_CRYSTAL) chk({2'h0, o_clock_out_pin_out, o_clock_out_pin_oe}, 4'h0);
      chk({2'h0, o_clock_in_pin_out, o_clock_in_pin_oe},
          {2'h0, oc && i_port_a_bit_seven_out, oc && i_port_a_bit_seven_oe});
      if (em inside {4'h3, 4'h4, 4'h9}) begin
        for (int k = 0; k < 8; k++) begin
          wav[k] = o_clock_out_pin_out;
          @(negedge i_clk);
        end
        chk({3'h0, o_clock_out_pin_oe}, 4'h1);
        chk({3'h0, wav inside {8'h33, 8'h66, 8'hcc, 8'h99}}, 4'h1);
      end
    end
    // second reset late in the run must restore the reset mode, then reload
    i_rst = 1'b1;
    @(negedge i_clk);
    chk(o_active_mode, OMS_MODE_RESET);
    chk({o_clock_origin, o_crystal_pll_en, o_slow_on_chip_en}, {OMS_ORIGIN_RC, 2'h0});
    @(negedge i_clk) i_rst = 1'b0;
    repeat (3) @(negedge i_clk);
    chk(o_active_mode, em);
    test_done();
  end
endmodule
